// File: rtl/ccr_config_regs.sv
// Main configuration and output common-mode registers with their control decode.
// Assumes a synchronous write/read port from the serial control logic.
`timescale 1ns/1ps
module ccr_config_regs
   import ccr_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic wr_en_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   output logic [15:0] rdata_o,
   input wire logic extended_control_mode_i,
   input wire logic demux_mode_i,
   input wire logic cal_pin_i,
   input wire logic inphase_pd_pin_i,
   input wire logic quadrature_pd_pin_i,
   input wire logic pin_ddr_phase_select_i,
   input wire logic pin_swing_high_i,
   input wire logic pin_dual_edge_i,
   input wire logic pin_dual_edge_input_select_i,
   input wire logic pin_twos_complement_i,
   output logic cal_start_o,
   output logic ddr_phase_select_o,
   output logic swing_high_o,
   output logic test_pattern_enable_o,
   output logic inphase_power_down_o,
   output logic quadrature_power_down_o,
   output logic low_frequency_select_o,
   output logic dual_edge_mode_o,
   output logic dual_edge_input_select_o,
   output logic dual_edge_input_join_o,
   output logic joined_input_dual_edge_mode_o,
   output logic quadrature_dual_edge_mode_o,
   output logic twos_complement_select_o,
   output logic [2:0] common_mode_adjust_code_o
);
   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   logic [15:0] main_r;
   logic [15:0] vcmo_r;
   logic [15:0] rdata_r;
   wire wr_main = wr_en_i && (addr_i == CCR_MAIN_ADDR);
   wire wr_vcmo = wr_en_i && (addr_i == CCR_VCMO_ADDR);

   // Bits stored as written; calibration bit never self-clears
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         main_r <= CCR_MAIN_RST;
         vcmo_r <= CCR_VCMO_RST;
         rdata_r <= 16'h0000;
      end else if (clk_en_i) begin
         if (wr_main) main_r <= wdata_i;
         if (wr_vcmo) vcmo_r <= wdata_i;
         rdata_r <= (addr_i == CCR_MAIN_ADDR) ? main_r :
                    (addr_i == CCR_VCMO_ADDR) ? vcmo_r : 16'h0000;
      end
   end
   assign rdata_o = rdata_r;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic cal_pin_s;
   logic pdi_pin_s;
   logic pdq_pin_s;
   logic ecm_pin_s;
   logic demux_s;
   logic dps_pin_s;
   logic swing_pin_s;
   logic des_pin_s;
   logic sel_pin_s;
   logic fmt_pin_s;
   ccr_pin_sync u_cal_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i),
      .pin_i(cal_pin_i),
      .level_o(cal_pin_s)
   );
   ccr_pin_sync u_pdi_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i),
      .pin_i(inphase_pd_pin_i),
      .level_o(pdi_pin_s)
   );
   ccr_pin_sync u_pdq_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i),
      .pin_i(quadrature_pd_pin_i),
      .level_o(pdq_pin_s)
   );
   // Mode straps are pins too; a mode change lands four edges late
   ccr_pin_sync u_ecm_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i),
      .pin_i(extended_control_mode_i),
      .level_o(ecm_pin_s)
   );
   ccr_pin_sync u_demux_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i),
      .pin_i(demux_mode_i),
      .level_o(demux_s)
   );
   ccr_pin_sync u_dps_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i),
      .pin_i(pin_ddr_phase_select_i),
      .level_o(dps_pin_s)
   );
   ccr_pin_sync u_swing_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i),
      .pin_i(pin_swing_high_i),
      .level_o(swing_pin_s)
   );
   ccr_pin_sync u_des_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i),
      .pin_i(pin_dual_edge_i),
      .level_o(des_pin_s)
   );
   ccr_pin_sync u_sel_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i),
      .pin_i(pin_dual_edge_input_select_i),
      .level_o(sel_pin_s)
   );
   ccr_pin_sync u_fmt_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i),
      .pin_i(pin_twos_complement_i),
      .level_o(fmt_pin_s)
   );

   // ----------------------------------------
   // Control decode
   // ----------------------------------------
   // Outside extended mode the register contents are ignored
   wire extended_control_mode = ecm_pin_s;
   wire cal_bit = extended_control_mode & main_r[CCR_CAL_BIT];
   wire cal_req = cal_bit | cal_pin_s;
   wire dps_sel = extended_control_mode ? main_r[CCR_DPS_BIT] : dps_pin_s;
   wire dps_eff = demux_s & dps_sel;
   wire swing_nxt = extended_control_mode ? main_r[CCR_SWING_BIT] : swing_pin_s;
   wire tpm_nxt = extended_control_mode & main_r[CCR_TPM_BIT];
   wire pdi_nxt = pdi_pin_s | (extended_control_mode & main_r[CCR_PDI_BIT]);
   wire pdq_nxt = pdq_pin_s | (extended_control_mode & main_r[CCR_PDQ_BIT]);
   wire lfs_nxt = extended_control_mode & main_r[CCR_LFS_BIT];
   wire des_nxt = extended_control_mode ? main_r[CCR_DES_BIT] : des_pin_s;
   wire deq_nxt = des_nxt & (extended_control_mode ? main_r[CCR_DEQ_BIT] : sel_pin_s);
   wire diq_nxt = des_nxt & extended_control_mode & main_r[CCR_DIQ_BIT];
   wire joined_input_dual_edge_mode_nxt = extended_control_mode && (main_r[CCR_DES_BIT:CCR_DIQ_BIT] == CCR_JOINED_INPUT_DUAL_EDGE_MODE_CODE);
   wire fmt_nxt = extended_control_mode ? main_r[CCR_FMT_BIT] : fmt_pin_s;
   wire [2:0] vca_nxt = extended_control_mode ? vcmo_r[CCR_VCA_LSB +: CCR_VCA_W] : 3'h0;

   ccr_cal_trig u_cal_trig (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i),
      .req_i(cal_req),
      .start_o(cal_start_o)
   );

   // ----------------------------------------
   // Registered control outputs
   // ----------------------------------------
   logic [13:0] ctl_r;
   logic [2:0] vca_r;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctl_r <= 14'h0000;
         vca_r <= 3'h0;
      end else if (clk_en_i) begin
         ctl_r <= {dps_eff, swing_nxt, tpm_nxt, pdi_nxt, pdq_nxt, lfs_nxt, des_nxt,
                   deq_nxt, diq_nxt, joined_input_dual_edge_mode_nxt, des_nxt & deq_nxt, fmt_nxt, 2'b00};
         vca_r <= vca_nxt;
      end
   end
   assign ddr_phase_select_o = ctl_r[13];
   assign swing_high_o = ctl_r[12];
   assign test_pattern_enable_o = ctl_r[11];
   assign inphase_power_down_o = ctl_r[10];
   assign quadrature_power_down_o = ctl_r[9];
   assign low_frequency_select_o = ctl_r[8];
   assign dual_edge_mode_o = ctl_r[7];
   assign dual_edge_input_select_o = ctl_r[6];
   assign dual_edge_input_join_o = ctl_r[5];
   assign joined_input_dual_edge_mode_o = ctl_r[4];
   assign quadrature_dual_edge_mode_o = ctl_r[3];
   assign twos_complement_select_o = ctl_r[2];
   assign common_mode_adjust_code_o = vca_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence main_write_s;
      clk_en_i && wr_main;
   endsequence
   cal_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      main_r[CCR_CAL_BIT] && !wr_main |=> main_r[CCR_CAL_BIT])
      else $error("calibration bit cleared without write");
   write_store_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      main_write_s |=> main_r == $past(wdata_i))
      else $error("main register write lost");
   pd_pin_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      clk_en_i && pdi_pin_s |=> inphase_power_down_o)
      else $error("in-phase pin power-down ignored");
   pdq_reg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      clk_en_i && extended_control_mode && main_r[CCR_PDQ_BIT] |=> quadrature_power_down_o)
      else $error("quadrature power-down ignored");
   ecm_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      clk_en_i && !extended_control_mode |=> !test_pattern_enable_o && common_mode_adjust_code_o == 3'h0)
      else $error("register acts outside extended mode");
   phase_nodemux_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      clk_en_i && !demux_s |=> !ddr_phase_select_o)
      else $error("phase select active without demux");
   join_mode_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      clk_en_i && !des_nxt |=> !dual_edge_input_join_o && !dual_edge_input_select_o)
      else $error("input join outside dual-edge mode");
   cal_start_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      clk_en_i && cal_req && !$past(cal_req) && $past(clk_en_i) |=> cal_start_o)
      else $error("calibration not started");
   vca_follow_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      clk_en_i && extended_control_mode |=> common_mode_adjust_code_o == $past(vcmo_r[7:5]))
      else $error("common-mode code mismatch");

   // ----------------------------------------
   // Per-field decode checks, plus common-mode store and main read checks
   // ----------------------------------------
   sequence ecm_on_s;
      clk_en_i && extended_control_mode;
   endsequence
   sequence ecm_off_s;
      clk_en_i && !extended_control_mode;
   endsequence
   swing_reg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ecm_on_s |=> swing_high_o == $past(main_r[CCR_SWING_BIT]))
      else $error("swing does not follow register");
   swing_pin_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ecm_off_s |=> swing_high_o == $past(swing_pin_s))
      else $error("swing does not follow pin");
   tpm_reg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ecm_on_s |=> test_pattern_enable_o == $past(main_r[CCR_TPM_BIT]))
      else $error("test pattern does not follow register");
   pdi_reg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ecm_on_s ##0 main_r[CCR_PDI_BIT] |=> inphase_power_down_o)
      else $error("in-phase power-down ignored");
   pdi_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      clk_en_i && !pdi_pin_s && !(extended_control_mode && main_r[CCR_PDI_BIT]) |=> !inphase_power_down_o)
      else $error("in-phase powered down unasked");
   pdq_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      clk_en_i && !pdq_pin_s && !(extended_control_mode && main_r[CCR_PDQ_BIT]) |=> !quadrature_power_down_o)
      else $error("quadrature powered down unasked");
   pdq_pin_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      clk_en_i && pdq_pin_s |=> quadrature_power_down_o)
      else $error("quadrature pin power-down ignored");
   lfs_reg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ecm_on_s |=> low_frequency_select_o == $past(main_r[CCR_LFS_BIT]))
      else $error("low-frequency select mismatch");
   lfs_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ecm_off_s |=> !low_frequency_select_o)
      else $error("low-frequency select outside extended mode");
   des_reg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ecm_on_s |=> dual_edge_mode_o == $past(main_r[CCR_DES_BIT]))
      else $error("dual-edge mode does not follow register");
   des_pin_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ecm_off_s |=> dual_edge_mode_o == $past(des_pin_s))
      else $error("dual-edge mode does not follow pin");
   desel_reg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ecm_on_s ##0 main_r[CCR_DES_BIT] |=> dual_edge_input_select_o == $past(main_r[CCR_DEQ_BIT]))
      else $error("input select mismatch");
   qdes_mode_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      clk_en_i |=> quadrature_dual_edge_mode_o == (dual_edge_mode_o && dual_edge_input_select_o))
      else $error("quadrature dual-edge mode mismatch");
   join_reg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ecm_on_s ##0 main_r[CCR_DES_BIT] |=> dual_edge_input_join_o == $past(main_r[CCR_DIQ_BIT]))
      else $error("input join mismatch");
   joined_code_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ecm_on_s |=> joined_input_dual_edge_mode_o == ($past(main_r[CCR_DES_BIT:CCR_DIQ_BIT]) == CCR_JOINED_INPUT_DUAL_EDGE_MODE_CODE))
      else $error("joined-input mode mismatch");
   fmt_reg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ecm_on_s |=> twos_complement_select_o == $past(main_r[CCR_FMT_BIT]))
      else $error("format does not follow register");
   fmt_pin_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ecm_off_s |=> twos_complement_select_o == $past(fmt_pin_s))
      else $error("format does not follow pin");
   phase_reg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ecm_on_s ##0 demux_s |=> ddr_phase_select_o == $past(main_r[CCR_DPS_BIT]))
      else $error("phase select mismatch");
   vcmo_store_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      clk_en_i && wr_vcmo |=> vcmo_r == $past(wdata_i))
      else $error("common-mode register write lost");
   rdata_main_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      clk_en_i && addr_i == CCR_MAIN_ADDR |=> rdata_o == $past(main_r))
      else $error("main register read mismatch");
endmodule : ccr_config_regs

// File: rtl/ccr_pkg.sv
// Constants for the converter configuration register bank.
// Assumes a single 200 MHz clock and a documented register write port.
// How it works
// - Writing one to calibration bit starts an on-command calibration.
// - Calibration bit stays set; software clears then sets for another calibration.
// - Calibration request is register bit OR pin; both low before raising.
// - Phase select bit chooses 0 or 90 degree output data to clock phase.
// - Phase select ignored while outputs are not demultiplexed.
// - Output swing bit selects lower or higher differential output level.
// - Test pattern bit drives fixed pattern instead of converted samples.
// - In-phase power-down bit powers down that channel when one.
// - Quadrature power-down bit powers down that channel when one.
// - Channel powers down if its pin or its register bit asks.
// - Dual-edge bit selects normal two-channel or dual-edge sampling.
// - In dual-edge mode, input select picks in-phase (0) or quadrature (1).
// - In dual-edge mode, join bit connects both inputs together.
// - Format bit selects offset binary or two's complement coding.
// - Common-mode code lowers output common mode about 28.6 mV per step.
// - Registers take effect only in extended control mode.
package ccr_pkg;
   localparam logic [3:0] CCR_MAIN_ADDR = 4'h0;
   localparam logic [3:0] CCR_VCMO_ADDR = 4'h1;
   localparam logic [15:0] CCR_MAIN_RST = 16'h2000;
   localparam logic [15:0] CCR_VCMO_RST = 16'h2A00;
   localparam int CCR_CAL_BIT = 15;
   localparam int CCR_DPS_BIT = 14;
   localparam int CCR_SWING_BIT = 13;
   localparam int CCR_TPM_BIT = 12;
   localparam int CCR_PDI_BIT = 11;
   localparam int CCR_PDQ_BIT = 10;
   localparam int CCR_LFS_BIT = 8;
   localparam int CCR_DES_BIT = 7;
   localparam int CCR_DEQ_BIT = 6;
   localparam int CCR_DIQ_BIT = 5;
   localparam int CCR_FMT_BIT = 4;
   localparam int CCR_VCA_LSB = 5;
   localparam int CCR_VCA_W = 3;
   localparam logic [2:0] CCR_JOINED_INPUT_DUAL_EDGE_MODE_CODE = 3'h5;
   localparam int CCR_SYNC_STAGES = 3;
endpackage : ccr_pkg

// File: rtl/ccr_pin_sync.sv
// Three-stage pin synchroniser; output changes when stages two and three agree.
// Assumes an asynchronous pin input and a single clock.
`timescale 1ns/1ps
module ccr_pin_sync
   import ccr_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic pin_i,
   output logic level_o
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic level_r;
   wire agree = (s2_r == s3_r);

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         level_r <= 1'b0;
      end else if (clk_en_i) begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (agree) level_r <= s3_r;
      end
   end
   assign level_o = level_r;
endmodule : ccr_pin_sync

// File: rtl/ccr_cal_trig.sv
// Rising-edge detector on the combined calibration request.
// Assumes request is synchronous to ref_clk_i.
`timescale 1ns/1ps
module ccr_cal_trig
   import ccr_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic req_i,
   output logic start_o
);
   logic req_d_r;
   logic start_r;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_d_r <= 1'b0;
         start_r <= 1'b0;
      end else if (clk_en_i) begin
         req_d_r <= req_i;
         start_r <= req_i & ~req_d_r;
      end
   end
   assign start_o = start_r;

   cal_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      clk_en_i && $past(clk_en_i) && start_o |-> !$past(start_o))
      else $error("calibration start repeated");
endmodule : ccr_cal_trig

// File: dv/ccr_config_regs_tb.sv
// Self-checking bench for the converter configuration register bank.
// Assumes the design carries its own assertions; the bench drives every port.
`timescale 1ns/1ps
module ccr_config_regs_tb;
   import ccr_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic clk_en_i = 1'b1;
   logic wr_en_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic extended_control_mode = 1'b1;
   logic demux = 1'b0;
   logic [7:0] pins = 8'h00; // cal, pdi, pdq, ddr, swing, des, sel, fmt
   wire [15:0] rdata_o;
   wire [14:0] outs;
   wire cal_start;
   int n_fail = 0;
   int tests_run = 0;
   int cycles = 0;

   initial begin
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   ccr_config_regs dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .wr_en_i(wr_en_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .extended_control_mode_i(extended_control_mode),
      .demux_mode_i(demux), .cal_pin_i(pins[0]), .inphase_pd_pin_i(pins[1]), .quadrature_pd_pin_i(pins[2]),
      .pin_ddr_phase_select_i(pins[3]), .pin_swing_high_i(pins[4]), .pin_dual_edge_i(pins[5]),
      .pin_dual_edge_input_select_i(pins[6]), .pin_twos_complement_i(pins[7]), .cal_start_o(cal_start),
      .ddr_phase_select_o(outs[0]), .swing_high_o(outs[1]), .test_pattern_enable_o(outs[2]),
      .inphase_power_down_o(outs[3]), .quadrature_power_down_o(outs[4]), .low_frequency_select_o(outs[5]),
      .dual_edge_mode_o(outs[6]), .dual_edge_input_select_o(outs[7]), .dual_edge_input_join_o(outs[8]),
      .joined_input_dual_edge_mode_o(outs[9]), .quadrature_dual_edge_mode_o(outs[10]),
      .twos_complement_select_o(outs[11]), .common_mode_adjust_code_o(outs[14:12]));

   // ---------------------------------------------
   // Expectations and bus tasks
   // ---------------------------------------------
   function automatic logic [14:0] exp_out(logic [15:0] m, logic [15:0] c, logic e, logic [7:0] p);
      logic [14:0] x;
      if (e) begin
         x = {c[7:5], m[4], m[7] & m[6], m[7:5] == 3'h5, m[5], m[6], m[7], m[8],
              m[10] | p[2], m[11] | p[1], m[12], m[13], m[14]};
      end else begin
         // Pin mode: register contents ignored entirely
         x = {3'h0, p[7], p[5] & p[6], 1'b0, 1'b0, p[6], p[5], 1'b0, p[2], p[1], 1'b0, p[4], p[3]};
      end
      return x;
   endfunction : exp_out

   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(negedge ref_clk_i);
      wr_en_i = 1'b1;
      addr_i = a;
      wdata_i = d;
      @(negedge ref_clk_i);
      wr_en_i = 1'b0;
   endtask : wr

   task automatic rd(logic [3:0] a, logic [15:0] e);
      @(negedge ref_clk_i);
      addr_i = a;
      @(negedge ref_clk_i);
      chk("rdata", e, rdata_o);
   endtask : rd

   // Counting over a window avoids pinning the exact launch cycle
   task automatic pulses(int n, int e);
      int k;
      k = 0;
      repeat (n) begin
         @(negedge ref_clk_i);
         if (cal_start === 1'b1) k++;
      end
      chk("cal_start count", 16'(e), 16'(k));
   endtask : pulses

   task automatic give_verdict;
      if (n_fail == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict

   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         give_verdict();
      end
   end

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      logic [15:0] m;
      logic [15:0] c;
      logic [14:0] x;
      logic [14:0] k;
      void'($urandom(38));
      repeat (20) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      rd(CCR_MAIN_ADDR, CCR_MAIN_RST);
      rd(CCR_VCMO_ADDR, CCR_VCMO_RST);
      rd(4'h7, 16'h0000);
      chk("reset outputs", 16'(exp_out(CCR_MAIN_RST, CCR_VCMO_RST, 1'b1, 8'h00) & 15'h7FFE), 16'(outs & 15'h7FFE));
      wr(4'h2, 16'hFFFF);
      rd(CCR_MAIN_ADDR, CCR_MAIN_RST);
      clk_en_i = 1'b0;
      wr(CCR_MAIN_ADDR, 16'h1234);
      clk_en_i = 1'b1;
      rd(CCR_MAIN_ADDR, CCR_MAIN_RST);
      // Calibration by bit, by pin, and pin blocked while the bit is high
      wr(CCR_MAIN_ADDR, 16'h8000);
      pulses(10, 1);
      pulses(10, 0);
      wr(CCR_MAIN_ADDR, 16'h0000);
      pulses(10, 0);
      wr(CCR_MAIN_ADDR, 16'h8000);
      pulses(10, 1);
      pins[0] = 1'b1;
      pulses(12, 0);
      wr(CCR_MAIN_ADDR, 16'h0000);
      pulses(12, 0);
      pins[0] = 1'b0;
      pulses(12, 0);
      pins[0] = 1'b1;
      pulses(12, 1);
      pins[0] = 1'b0;
      pulses(12, 0);
      for (int i = 0; i < 24; i++) begin
         m = (i == 0) ? 16'h00A0 : (i == 1) ? 16'h00C0 : (16'($urandom) & 16'hFDF0);
         c = (16'($urandom) & 16'h00E0) | (CCR_VCMO_RST & 16'hFF1F);
         extended_control_mode = (i < 2) ? 1'b1 : 1'($urandom);
         demux = 1'($urandom);
         pins = 8'($urandom) & 8'hFE;
         wr(CCR_MAIN_ADDR, m);
         wr(CCR_VCMO_ADDR, c);
         repeat (8) @(negedge ref_clk_i);
         x = exp_out(m, c, extended_control_mode, pins);
         k = 15'h7FFF;
         if (!demux) k[0] = 1'b0;
         if (!x[6]) k[8:7] = 2'b00;
         chk("outputs", 16'(x & k), 16'(outs & k));
         rd(CCR_MAIN_ADDR, m);
         rd(CCR_VCMO_ADDR, c);
      end
      give_verdict();
   end
endmodule : ccr_config_regs_tb
